//--- core/arm_regbank.sv
/*
  Converter result and control register bank, Wishbone classic slave.
  Assumes the converter core, comparators and sequencer run on clk_i and
  hand results and status in directly; trims are stable at reset release.
*/
// The implementer's own choice: the Wishbone slave port.
// Function
// - One read-only result word per channel, four bytes apart.
// - Every result word reads zero after reset until a conversion lands.
// - Result value sits from bit 4 upward; bits 31:20 read zero.
// - Slots 0 to 15 hold external analog inputs 0 to 15.
// - Slots 16 to 19 hold gain amplifier channels 0 to 3.
// - Slot 20 die sensor; 21 to 23 supply measurements.
// - Slots 24 to 28 reserved; slot 29 ground or digital supply half.
// - Ready flag sets on a new result, clears once that result is read.
// - Underflow flag set when stored value is zero scale, else zero.
// - Overflow flag set when stored value is full scale, else zero.
// - Config resets to 0x200; irq and sequencer status read-only, zero.
// - External cycle resets to 0x10, internal cycle to 0x140.
// - Differential and die sensor trims load factory values; writable.
// - Four amplifier trims reset to 0x4000, read and write.
// - Four comparator configs reset to 0x40000; shared flags reset zero.
// - Die sensor control resets to 0x2, its chopping control to zero.
// - Amp bias 0x3F, chop controls 0x1, amp controls 0x9 or 0x11.
// - With chop on, two die sensor samples are averaged, then stored.
// - Config bit 8 selects what internal channel 29 measures.
`timescale 1ns/1ps
`default_nettype none
`include "arm_map.svh"

module arm_regbank
  import arm_pkg::*;
#(
  parameter int DATA_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire arm_wb_req_s wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire arm_conv_s conv_i,
  input wire arm_trim_s trim_i,
  input wire logic [31:0] conv_irq_i,
  input wire logic [31:0] seq_state_i,
  input wire logic [3:0] cmp_event_i,
  output logic [`ARM_NCFG-1:0][31:0] cfg_bank_o,
  output logic ch29_sel_o,
  output logic temp_chop_o
);

  // --------------------------------------------------------------------
  // Elaboration checks and tables
  // --------------------------------------------------------------------
  if (DATA_W < 1 || DATA_W > 16) begin : g_bad_width
    $error("DATA_W must be 1 to 16");
  end

  localparam int NCFG = `ARM_NCFG;
  localparam int NSLOT = `ARM_SLOTS;
  localparam logic [15:0] FULL_SCALE = 16'(({DATA_W{1'b1}}));

  // Order here fixes the index of each control word in cfg_bank_o
  localparam logic [31:0] CFG_ADDR [NCFG] = '{
    `ARM_A_CONV_CFG, `ARM_A_PREBUF, `ARM_A_EXT_CYC, `ARM_A_INT_CYC,
    `ARM_A_CHAN_SEL, `ARM_A_SEQ_CTRL, `ARM_A_SEQ_CFG, `ARM_A_SEQ_SLOT,
    `ARM_A_MUX_A, `ARM_A_MUX_B, `ARM_A_CMP0, `ARM_A_CMP_IRQ,
    `ARM_A_DIFF_TRIM, `ARM_A_TOFS_TRIM, `ARM_A_TGN_TRIM,
    `ARM_A_AMP0_TRIM, `ARM_A_AMP1_TRIM, `ARM_A_AMP2_TRIM,
    `ARM_A_AMP3_TRIM, `ARM_A_CMP1, `ARM_A_CMP2, `ARM_A_CMP3,
    `ARM_A_BIAS, `ARM_A_AMP0_CTRL, `ARM_A_AMP0_CHOP, `ARM_A_AMP3_CHOP,
    `ARM_A_AMP1_CTRL, `ARM_A_AMP1_CHOP, `ARM_A_AMP2_CTRL,
    `ARM_A_AMP2_CHOP, `ARM_A_AMP3_CTRL, `ARM_A_SNS_CTRL, `ARM_A_SNS_CHOP
  };

  localparam logic [31:0] CFG_RST [NCFG] = '{
    `ARM_R_CONV_CFG, `ARM_R_PREBUF, `ARM_R_EXT_CYC, `ARM_R_INT_CYC,
    `ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_ZERO,
    `ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_CMP, `ARM_R_ZERO,
    `ARM_R_ZERO, `ARM_R_ZERO, `ARM_R_ZERO,
    `ARM_R_AMP_TRIM, `ARM_R_AMP_TRIM, `ARM_R_AMP_TRIM,
    `ARM_R_AMP_TRIM, `ARM_R_CMP, `ARM_R_CMP, `ARM_R_CMP,
    `ARM_R_BIAS, `ARM_R_AMP_A, `ARM_R_CHOP, `ARM_R_CHOP,
    `ARM_R_AMP_B, `ARM_R_CHOP, `ARM_R_AMP_A,
    `ARM_R_CHOP, `ARM_R_AMP_B, `ARM_R_SNS_CTRL, `ARM_R_ZERO
  };

  // --------------------------------------------------------------------
  // Decode functions, shared by read mux, write path and read-clear
  // --------------------------------------------------------------------
  // Result slot hit: word aligned, inside the result window
  function automatic logic res_hit(input logic [31:0] a);
    res_hit = (a >= `ARM_RES_BASE) && (a <= `ARM_RES_LAST)
              && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] res_slot(input logic [31:0] a);
    logic [31:0] off;
    off = a - `ARM_RES_BASE;
    res_slot = off[6:2];
  endfunction

  // Only slots with a documented source ever take a result
  function automatic logic slot_live(input logic [4:0] s);
    slot_live = (s < `ARM_SLOT_RSV_LO) || (s == `ARM_SLOT_INT29);
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    byte_merge = m;
  endfunction

  // --------------------------------------------------------------------
  // Wishbone slave handshake
  // --------------------------------------------------------------------
  logic ack_reg;
  logic [31:0] dat_reg;
  logic req;
  logic done;
  logic rd_done;
  logic wr_done;
  logic [4:0] req_slot;
  logic req_res;

  assign req = wb_req_i.cyc && wb_req_i.stb;
  // The access completes at the edge where the master sees ack
  assign done = req && ack_reg;
  assign rd_done = done && !wb_req_i.we;
  assign wr_done = done && wb_req_i.we;
  assign req_slot = res_slot(wb_req_i.adr);
  assign req_res = res_hit(wb_req_i.adr);

  // One wait state, then ack for one cycle; never back to back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // --------------------------------------------------------------------
  // Control word storage
  // --------------------------------------------------------------------
  logic [NCFG-1:0][31:0] cfg_reg;
  logic [31:0] conv_irq_reg;
  logic [31:0] seq_state_reg;
  logic trim_load_reg;

  // Trims come from fuses, which are only valid after reset lets go
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim_load_reg <= 1'b1;
    end else begin
      trim_load_reg <= 1'b0;
    end
  end

  // Each control word: reset value, byte-masked write; the three trims also take a factory load
  for (genvar i = 0; i < NCFG; i++) begin : g_cfg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_reg[i] <= CFG_RST[i];
      end else if (trim_load_reg && i == `ARM_I_DIFF_TRIM) begin
        cfg_reg[i] <= trim_i.diff;
      end else if (trim_load_reg && i == `ARM_I_TOFS_TRIM) begin
        cfg_reg[i] <= trim_i.temp_ofs;
      end else if (trim_load_reg && i == `ARM_I_TGN_TRIM) begin
        cfg_reg[i] <= trim_i.temp_gain;
      end else if (i == `ARM_I_CMP_IRQ) begin
        // A comparator hit in the write cycle survives the write
        if (wr_done && wb_req_i.adr == CFG_ADDR[i]) begin
          cfg_reg[i] <= byte_merge(cfg_reg[i], wb_req_i.dat,
                                   wb_req_i.sel) | {28'h0, cmp_event_i};
        end else begin
          cfg_reg[i] <= cfg_reg[i] | {28'h0, cmp_event_i};
        end
      end else if (wr_done && wb_req_i.adr == CFG_ADDR[i]) begin
        cfg_reg[i] <= byte_merge(cfg_reg[i], wb_req_i.dat,
                                 wb_req_i.sel);
      end
    end
  end

  // Read-only status mirrors; bus writes never reach them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_irq_reg <= `ARM_R_ZERO;
      seq_state_reg <= `ARM_R_ZERO;
    end else begin
      conv_irq_reg <= conv_irq_i;
      seq_state_reg <= seq_state_i;
    end
  end

  // --------------------------------------------------------------------
  // Die sensor two-sample averaging
  // --------------------------------------------------------------------
  arm_chop_e chop_state;
  logic [15:0] chop_first_reg;
  logic temp_hit;
  logic chop_on;
  logic store;
  logic [4:0] store_slot;
  logic [15:0] store_value;
  logic [16:0] chop_sum;

  assign temp_hit = conv_i.valid && conv_i.slot == `ARM_SLOT_TEMP;
  assign chop_on = cfg_reg[`ARM_I_SNS_CHOP][`ARM_TCHOP_EN_BIT];
  assign chop_sum = {1'b0, chop_first_reg} + {1'b0, conv_i.value};

  // First sample parks here; only the mean of the pair is stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chop_state <= ARM_CHOP_IDLE;
      chop_first_reg <= 16'h0000;
    end else begin
      case (chop_state)
        ARM_CHOP_IDLE: begin
          if (temp_hit && chop_on) begin
            chop_state <= ARM_CHOP_HALF;
            chop_first_reg <= conv_i.value;
          end
        end
        ARM_CHOP_HALF: begin
          if (temp_hit || !chop_on) begin
            chop_state <= ARM_CHOP_IDLE;
          end
        end
        default: begin
          chop_state <= ARM_CHOP_IDLE;
        end
      endcase
    end
  end

  // Value and slot actually written this cycle
  always_comb begin
    store = conv_i.valid && slot_live(conv_i.slot);
    store_slot = conv_i.slot;
    store_value = conv_i.value & FULL_SCALE;
    if (temp_hit && chop_on) begin
      // Turning chop off mid-pair drops the parked half
      store = (chop_state == ARM_CHOP_HALF);
      store_value = chop_sum[16:1] & FULL_SCALE;
    end
  end

  // --------------------------------------------------------------------
  // Result slots
  // --------------------------------------------------------------------
  logic [15:0] res_value [NSLOT];
  logic [NSLOT-1:0] res_rdy;
  logic [NSLOT-1:0] res_uvf;
  logic [NSLOT-1:0] res_ovf;

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    logic hit_set;
    logic hit_clr;
    assign hit_set = store && store_slot == 5'(s);
    assign hit_clr = rd_done && req_res && req_slot == 5'(s);

    // Value and range flags follow the stored sample
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        res_value[s] <= 16'h0000;
        res_uvf[s] <= 1'b0;
        res_ovf[s] <= 1'b0;
      end else if (hit_set) begin
        res_value[s] <= store_value;
        res_uvf[s] <= (store_value == 16'h0000);
        res_ovf[s] <= (store_value == FULL_SCALE);
      end
    end

    // A fresh result landing with the read keeps ready set
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        res_rdy[s] <= 1'b0;
      end else if (hit_set) begin
        res_rdy[s] <= 1'b1;
      end else if (hit_clr) begin
        res_rdy[s] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  logic [31:0] rd_mux;

  // Unmapped and reserved addresses answer zero
  always_comb begin
    rd_mux = `ARM_R_ZERO;
    if (req_res) begin
      if (slot_live(req_slot)) begin
        rd_mux[`ARM_VAL_MSB:`ARM_VAL_LSB] = res_value[req_slot];
        rd_mux[`ARM_RDY_BIT] = res_rdy[req_slot];
        rd_mux[`ARM_UVF_BIT] = res_uvf[req_slot];
        rd_mux[`ARM_OVF_BIT] = res_ovf[req_slot];
      end
    end else if (wb_req_i.adr == `ARM_A_CONV_IRQ) begin
      rd_mux = conv_irq_reg;
    end else if (wb_req_i.adr == `ARM_A_SEQ_STATE) begin
      rd_mux = seq_state_reg;
    end else begin
      for (int i = 0; i < NCFG; i++) begin
        if (wb_req_i.adr == CFG_ADDR[i]) begin
          rd_mux = cfg_reg[i];
        end
      end
    end
  end

  // Data is captured with the ack so it stands while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= `ARM_R_ZERO;
    end else if (req && !ack_reg && !wb_req_i.we) begin
      dat_reg <= rd_mux;
    end
  end

  // --------------------------------------------------------------------
  // Control outputs
  // --------------------------------------------------------------------
  logic ch29_reg;
  logic tchop_reg;
  logic [NCFG-1:0][31:0] cfg_out_reg;

  // Registered copies keep outputs straight off flip-flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch29_reg <= 1'b0;
      tchop_reg <= 1'b0;
    end else begin
      ch29_reg <= cfg_reg[`ARM_I_CONV_CFG][`ARM_CH29_SEL_BIT];
      tchop_reg <= chop_on;
    end
  end

  for (genvar i = 0; i < NCFG; i++) begin : g_cfg_out
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cfg_out_reg[i] <= CFG_RST[i];
      end else begin
        cfg_out_reg[i] <= cfg_reg[i];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign cfg_bank_o = cfg_out_reg;
  assign ch29_sel_o = ch29_reg;
  assign temp_chop_o = tchop_reg;

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse;
    ack_reg |=> !ack_reg;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_rdy_set;
    store && store_slot == 5'h00 |=> res_rdy[0] ##0 res_value[0] ==
      $past(store_value);
  endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("slot 0 not ready after a store");

  property p_rdy_clr;
    rd_done && req_res && req_slot == 5'h00 && !(store &&
      store_slot == 5'h00) |=> !res_rdy[0];
  endproperty
  a_rdy_clr: assert property (p_rdy_clr)
    else $error("slot 0 ready survived its read");

  property p_uvf;
    store && store_slot == 5'h01 |=> res_uvf[1] ==
      ($past(store_value) == 16'h0000);
  endproperty
  a_uvf: assert property (p_uvf)
    else $error("underflow flag disagrees with stored value");

  property p_ovf;
    store && store_slot == 5'h01 |=> res_ovf[1] ==
      ($past(store_value) == FULL_SCALE);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag disagrees with stored value");

  property p_rsv_read;
    req && !ack_reg && !wb_req_i.we && req_res && !slot_live(req_slot)
      |=> wb_ack_o && wb_dat_o == 32'h0;
  endproperty
  a_rsv_read: assert property (p_rsv_read)
    else $error("reserved slot did not read zero");

  property p_upper_zero;
    req && !ack_reg && !wb_req_i.we && req_res |=> wb_dat_o[31:20] ==
      12'h000 && wb_dat_o[3] == 1'b0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("reserved result bits not zero");

  property p_reset_vals;
    $past(rst_i) |-> cfg_reg[`ARM_I_CONV_CFG] == `ARM_R_CONV_CFG &&
      cfg_reg[2] == `ARM_R_EXT_CYC && cfg_reg[3] == `ARM_R_INT_CYC &&
      res_rdy == '0 && conv_irq_reg == 32'h0;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("control words wrong after reset");

  property p_chop_hold;
    chop_state == ARM_CHOP_IDLE && temp_hit && chop_on
      |=> $stable(res_value[20]) && chop_state == ARM_CHOP_HALF;
  endproperty
  a_chop_hold: assert property (p_chop_hold)
    else $error("first chopped sample reached slot 20");

  property p_ch29;
    wr_done && wb_req_i.adr == `ARM_A_CONV_CFG && wb_req_i.sel[1]
      |=> ##1 ch29_sel_o == $past(wb_req_i.dat[`ARM_CH29_SEL_BIT], 2);
  endproperty
  a_ch29: assert property (p_ch29)
    else $error("channel 29 select did not follow config bit");

  c_read_slot: cover property (rd_done && req_res && res_rdy[req_slot]);
  c_chop_pair: cover property (chop_state == ARM_CHOP_HALF ##[1:50]
    store && store_slot == `ARM_SLOT_TEMP);
  c_cfg_write: cover property (wr_done && wb_req_i.adr == `ARM_A_SNS_CHOP);
  c_set_clr: cover property (store && rd_done && req_res &&
    req_slot == store_slot);

endmodule
`default_nettype wire

//--- dv/arm_regbank_bench.sv
/*
  Self-checking bench for the converter result register bank.
  Assumes arm_wb_host as bus master; random data from a fixed seed.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arm_map.svh"
module arm_regbank_bench
  import arm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  arm_wb_req_s req;
  arm_conv_s conv = '0;
  arm_trim_s trim = '0;
  logic [31:0] irq = '0;
  logic [31:0] seq = '0;
  logic [3:0] cmp = '0;
  logic [31:0] rdat, q, a;
  logic ack, c29, tchop, hang;
  logic [`ARM_NCFG-1:0][31:0] cfg;
  int fail_count = 0;
  int checked = 0;
  logic [15:0] v, w;
  logic [4:0] s;
  logic [31:0] ra [10] = '{`ARM_A_CONV_CFG, `ARM_A_EXT_CYC,
    `ARM_A_INT_CYC, `ARM_A_CMP3, `ARM_A_AMP2_TRIM, `ARM_A_BIAS,
    `ARM_A_AMP1_CTRL, `ARM_A_AMP3_CHOP, `ARM_A_SNS_CTRL, `ARM_A_SEQ_STATE};
  logic [31:0] rv [10] = '{32'h200, 32'h10, 32'h140, 32'h40000,
    32'h4000, 32'h3F, 32'h11, 32'h1, 32'h2, 32'h0};

  always #12.5 clk_i = ~clk_i;

  arm_regbank dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
    .wb_dat_o(rdat), .wb_ack_o(ack), .conv_i(conv), .trim_i(trim),
    .conv_irq_i(irq), .seq_state_i(seq), .cmp_event_i(cmp),
    .cfg_bank_o(cfg), .ch29_sel_o(c29), .temp_chop_o(tchop));
  arm_wb_host host (.clk_i(clk_i), .dat_i(rdat), .ack_i(ack),
    .req_o(req), .hang_o(hang));

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready set; flags from zero and full scale of a 16-bit value
  function automatic logic [31:0] word(input logic [15:0] x);
    return {12'h000, x, 1'b0, 1'b1, x == 16'h0000, x == 16'hFFFF};
  endfunction
  task automatic rd(input logic [31:0] ad);
    host.xfer(1'b0, ad, 32'h0000_0000, q);
    if (hang) complete_run();
  endtask
  task automatic wr(input logic [31:0] ad, d);
    host.xfer(1'b1, ad, d, q);
    if (hang) complete_run();
  endtask
  task automatic cv(input logic [4:0] sl, input logic [15:0] x);
    @(posedge clk_i);
    conv <= '{1'b1, sl, x};
    @(posedge clk_i);
    conv <= '0;
  endtask
  task automatic complete_run();
    if (hang) fail_count++;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Hang guard; main run needs far fewer cycles
  initial begin
    #2000000;
    fail_count++;
    complete_run();
  end

  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    v = 16'($urandom(32'h076F_C68B));
    trim = {$urandom, $urandom, $urandom};
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(ra[i]);
      check(q, rv[i]);
    end
    for (int i = 0; i < 30; i++) begin
      rd(`ARM_RES_BASE + 32'(i * 4));
      check(q, 32'h0);
    end
    rd(`ARM_A_DIFF_TRIM);
    check(q, trim.diff);
    wr(`ARM_A_TGN_TRIM, 32'h1234_5678);
    rd(`ARM_A_TGN_TRIM);
    check(q, 32'h1234_5678);
    // Random slots, with both scale ends and slot 29 mixed in
    for (int i = 0; i < 40; i++) begin
      s = (i % 5 == 0) ? `ARM_SLOT_INT29 :
          (i < 4) ? 5'(i - 1) : 5'($urandom_range(23));
      v = (i == 1) ? 16'h0000 : (i == 2) ? 16'hFFFF : 16'($urandom);
      a = `ARM_RES_BASE + {25'h0, s, 2'b00};
      cv(s, v);
      wr(a, 32'hFFFF_FFFF);
      rd(a);
      check(q, word(v));
      rd(a);
      check(q, word(v) & 32'hFFFF_FFFB);
    end
    cv(5'h19, 16'h1234);
    rd(`ARM_RES_BASE + 32'h64);
    check(q, 32'h0);
    rd(32'h4006_8100);
    check(q, 32'h0);
    // Averaged die sensor pair
    wr(`ARM_A_CHAN_SEL, 32'h0000_0014);
    rd(`ARM_A_CHAN_SEL);
    check(q, 32'h0000_0014);
    wr(`ARM_A_SNS_CHOP, 32'h1);
    v = 16'($urandom);
    w = 16'($urandom);
    cv(`ARM_SLOT_TEMP, v);
    cv(`ARM_SLOT_TEMP, w);
    rd(`ARM_RES_BASE + 32'h50);
    check(q, word(16'((17'(v) + 17'(w)) >> 1)));
    check({31'h0, tchop}, 32'h1);
    check(cfg[`ARM_I_SNS_CHOP], 32'h1);
    wr(`ARM_A_CONV_CFG, 32'h0000_0300);
    rd(`ARM_A_CONV_CFG);
    check({31'h0, c29}, 32'h1);
    check(q, 32'h0000_0300);
    check(cfg[`ARM_I_CONV_CFG], 32'h0000_0300);
    // Status mirrors ignore writes; comparator hits stick
    @(posedge clk_i);
    irq <= 32'hA5A5_5A5A;
    a = $urandom;
    seq <= a;
    cmp <= 4'h5;
    @(posedge clk_i);
    cmp <= 4'h0;
    wr(`ARM_A_CONV_IRQ, 32'h0);
    rd(`ARM_A_CONV_IRQ);
    check(q, 32'hA5A5_5A5A);
    wr(`ARM_A_SEQ_STATE, 32'h0);
    rd(`ARM_A_SEQ_STATE);
    check(q, a);
    rd(`ARM_A_CMP_IRQ);
    check(q, 32'h5);
    wr(`ARM_A_CMP_IRQ, 32'h0);
    rd(`ARM_A_CMP_IRQ);
    check(q, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire

//--- dv/arm_wb_host.sv
/*
  Wishbone classic master standing in for the processor core.
  Assumes one clock and one access at a time through xfer.
*/
`timescale 1ns/1ps
`default_nettype none
module arm_wb_host
  import arm_pkg::*;
(
  input wire logic clk_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  output var arm_wb_req_s req_o,
  output var logic hang_o
);
  // -------------------------------------------------------------
  // One bus cycle
  // -------------------------------------------------------------
  initial begin
    req_o = '0;
    hang_o = 1'b0;
  end
  // Request held until ack is sampled or 16 cycles pass, then released at that edge
  task automatic xfer(input logic we, input logic [31:0] a, d,
                      output logic [31:0] q);
    int n;
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b1, we, 4'hF, a, d};
    for (n = 0; n < 16; n++) begin
      @(posedge clk_i);
      if (ack_i === 1'b1) break;
    end
    if (n == 16) hang_o = 1'b1;
    q = dat_i;
    req_o <= '0;
  endtask
endmodule
`default_nettype wire

//--- include/arm_map.svh
/*
  Address map, field positions and reset values of the converter result
  and control register bank.
  Assumes byte addresses on a 32-bit word bus; included by bare name.
*/
`ifndef ARM_MAP_SVH
`define ARM_MAP_SVH

// ----------------------------------------------------------------------
// Result words
// ----------------------------------------------------------------------
`define ARM_RES_BASE 32'h4006_8000
`define ARM_RES_LAST 32'h4006_8074
`define ARM_RES_STRIDE 32'h0000_0004
`define ARM_SLOTS 30
`define ARM_SLOT_GAIN_AMP_CHANNEL_0 5'h10
`define ARM_SLOT_TEMP 5'h14
`define ARM_SLOT_RSV_LO 5'h18
`define ARM_SLOT_RSV_HI 5'h1C
`define ARM_SLOT_INT29 5'h1D
`define ARM_OVF_BIT 0
`define ARM_UVF_BIT 1
`define ARM_RDY_BIT 2
`define ARM_VAL_LSB 4
`define ARM_VAL_MSB 19

// ----------------------------------------------------------------------
// Control registers, byte addresses
// ----------------------------------------------------------------------
`define ARM_A_CONV_CFG 32'h4006_8078
`define ARM_A_PREBUF 32'h4006_807C
`define ARM_A_EXT_CYC 32'h4006_8080
`define ARM_A_INT_CYC 32'h4006_8084
`define ARM_A_CHAN_SEL 32'h4006_8088
`define ARM_A_CONV_IRQ 32'h4006_808C
`define ARM_A_SEQ_CTRL 32'h4006_8090
`define ARM_A_SEQ_CFG 32'h4006_8094
`define ARM_A_SEQ_STATE 32'h4006_8098
`define ARM_A_SEQ_SLOT 32'h4006_809C
`define ARM_A_MUX_A 32'h4006_80A0
`define ARM_A_MUX_B 32'h4006_80A4
`define ARM_A_CMP0 32'h4006_80A8
`define ARM_A_CMP_IRQ 32'h4006_80AC
`define ARM_A_DIFF_TRIM 32'h4006_80B0
`define ARM_A_TOFS_TRIM 32'h4006_80B4
`define ARM_A_TGN_TRIM 32'h4006_80B8
`define ARM_A_AMP0_TRIM 32'h4006_80BC
`define ARM_A_AMP1_TRIM 32'h4006_80C0
`define ARM_A_AMP2_TRIM 32'h4006_80C4
`define ARM_A_AMP3_TRIM 32'h4006_80C8
`define ARM_A_CMP1 32'h4006_8154
`define ARM_A_CMP2 32'h4006_8158
`define ARM_A_CMP3 32'h4006_815C
`define ARM_A_BIAS 32'h4006_9000
`define ARM_A_AMP0_CTRL 32'h4006_9020
`define ARM_A_AMP0_CHOP 32'h4006_9024
`define ARM_A_AMP3_CHOP 32'h4006_9028
`define ARM_A_AMP1_CTRL 32'h4006_9070
`define ARM_A_AMP1_CHOP 32'h4006_9074
`define ARM_A_AMP2_CTRL 32'h4006_90A0
`define ARM_A_AMP2_CHOP 32'h4006_90A4
`define ARM_A_AMP3_CTRL 32'h4006_90D0
`define ARM_A_SNS_CTRL 32'h4006_9600
`define ARM_A_SNS_CHOP 32'h4006_9604

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define ARM_R_ZERO 32'h0000_0000
`define ARM_R_CONV_CFG 32'h0000_0200
`define ARM_R_PREBUF 32'h0000_0003
`define ARM_R_EXT_CYC 32'h0000_0010
`define ARM_R_INT_CYC 32'h0000_0140
`define ARM_R_CMP 32'h0004_0000
`define ARM_R_AMP_TRIM 32'h0000_4000
`define ARM_R_BIAS 32'h0000_003F
`define ARM_R_CHOP 32'h0000_0001
`define ARM_R_AMP_A 32'h0000_0009
`define ARM_R_AMP_B 32'h0000_0011
`define ARM_R_SNS_CTRL 32'h0000_0002
`define ARM_CH29_SEL_BIT 8
`define ARM_TCHOP_EN_BIT 0
`define ARM_NCFG 33
`define ARM_I_CONV_CFG 0
`define ARM_I_CMP_IRQ 11
`define ARM_I_DIFF_TRIM 12
`define ARM_I_TOFS_TRIM 13
`define ARM_I_TGN_TRIM 14
`define ARM_I_SNS_CHOP 32

`endif

//--- include/arm_pkg.sv
/*
  Types shared by the converter result register bank.
  Assumes arm_map.svh for all numeric constants.
*/
package arm_pkg;

  // Bus request from the Wishbone master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } arm_wb_req_s;

  // One finished conversion from the converter core
  typedef struct packed {
    logic valid;
    logic [4:0] slot;
    logic [15:0] value;
  } arm_conv_s;

  // Factory trim words presented at power-up
  typedef struct packed {
    logic [31:0] diff;
    logic [31:0] temp_ofs;
    logic [31:0] temp_gain;
  } arm_trim_s;

  // Die sensor two-sample averaging
  typedef enum logic {ARM_CHOP_IDLE, ARM_CHOP_HALF} arm_chop_e;

endpackage
